/* include/dpct_defs.vh */
`ifndef DPCT_DEFS_VH
`define DPCT_DEFS_VH

// Register byte addresses
`define DPCT_ADDR_CTRL      12'h000
`define DPCT_ADDR_T0_LOAD   12'h004
`define DPCT_ADDR_T0_PRE    12'h008
`define DPCT_ADDR_T0_COUNT  12'h00C
`define DPCT_ADDR_T1_LOAD   12'h010
`define DPCT_ADDR_T1_PRE    12'h014
`define DPCT_ADDR_T1_COUNT  12'h018
`define DPCT_ADDR_STATUS    12'h01C

// Control register fields
`define DPCT_CTRL_T0_RUN    0
`define DPCT_CTRL_T0_CONT   1
`define DPCT_CTRL_T1_RUN    2
`define DPCT_CTRL_T1_CONT   3
`define DPCT_CTRL_T1_EXT    4
`define DPCT_CTRL_TIN_LO    5
`define DPCT_CTRL_TIN_HI    6
`define DPCT_CTRL_CASCADE   7
`define DPCT_CTRL_TOUT_EN   8
`define DPCT_CTRL_WIDTH     9

// Write-one command bits in the control register
`define DPCT_CMD_T0_RELOAD  16
`define DPCT_CMD_T1_RELOAD  17

// External input modes
`define DPCT_TIN_CLOCK      2'h0
`define DPCT_TIN_GATE       2'h1
`define DPCT_TIN_TRIG_NR    2'h2
`define DPCT_TIN_TRIG_R     2'h3

// Internal clock divided by four for timer one
`define DPCT_INT_DIV        2'h3

`endif

/* rtl/dpct_sync.v */
`timescale 1ns/1ps
`default_nettype none

module dpct_sync (
  input  wire ref_clk,
  input  wire rst,
  input  wire din,
  output reg  level,
  output wire rise
);

  reg s1;
  reg s2;
  reg s3;

  // Change counts once the second and third stages agree
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end

  assign rise = (s2 == s3) && s3 && !level;

endmodule
`default_nettype wire

/* rtl/dpct_timer.v */
`timescale 1ns/1ps
`default_nettype none

module dpct_timer (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       tick_in,
  input  wire       run,
  input  wire       cont,
  input  wire       reload,
  input  wire [7:0] load_val,
  input  wire [5:0] pre_val,
  output reg  [7:0] count,
  output reg        done
);

  reg [5:0] pre_cnt;
  reg       halted;
  wire      pre_tick;

  // Prescaler divides by pre_val+1, giving 1 through 64
  assign pre_tick = tick_in && (pre_cnt == 6'h00);

  always @(posedge ref_clk)
  begin
    done <= 1'b0;
    if (rst)
    begin
      pre_cnt <= 6'h00;
      count   <= 8'h00;
      halted  <= 1'b1;
    end
    else if (reload)
    begin
      // Load value 0 stands for a count of 256
      pre_cnt <= pre_val;
      count   <= load_val;
      halted  <= 1'b0;
    end
    // Halted flag tells a spent single pass from a fresh load of 0
    else if (run && tick_in && !halted)
    begin
      if (pre_cnt == 6'h00)
        pre_cnt <= pre_val;
      else
        pre_cnt <= pre_cnt - 6'h01;
      if (pre_tick)
      begin
        if (count == 8'h01)
        begin
          done   <= 1'b1;
          count  <= cont ? load_val : 8'h00;
          halted <= !cont;
        end
        else
          count <= count - 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/dpct_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "dpct_defs.vh"

// Function
// - Two 8-bit down-counters, each with its own 6-bit prescaler.
// - Timer zero uses internal clock only; timer one internal or external.
// - Prescalers divide their source by 1 through 64.
// - Counter decrements per prescaler tick; load spans 1 to 256.
// - End of count raises timer_zero_irq or timer_one_irq.
// - Software starts, stops, resumes and restarts from loaded value.
// - Single-pass halts at zero; modulo-n reloads and continues.
// - Counter reads never disturb count or mode; prescaler counters unreadable.
// - Timer one source is internal clock divided by four or external input.
// - External input acts as clock, retrigger, non-retrigger trigger, or gate.
// - Timer zero output can cascade into timer one input.
// - Timer one uses port3_line1 input and port3_line6 output.
module dpct_top (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hsel,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        port3_line1,
  output reg         port3_line6,
  output reg         timer_zero_irq,
  output reg         timer_one_irq
);

  reg  [`DPCT_CTRL_WIDTH-1:0] ctrl;
  reg  [7:0]  t0_load;
  reg  [5:0]  t0_pre;
  reg  [7:0]  t1_load;
  reg  [5:0]  t1_pre;
  reg         t0_reload;
  reg         t1_reload;
  reg         wr_pend;
  reg  [11:0] wr_addr;
  reg  [1:0]  int_div;
  reg         trig_armed;
  wire [7:0]  t0_count;
  wire [7:0]  t1_count;
  wire        t0_done;
  wire        t1_done;
  wire        tin_level;
  wire        tin_rise;
  wire        addr_ok;
  wire        int_tick;
  wire [1:0]  tin_mode;
  reg         t1_tick;
  reg         t1_run;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1];
  assign tin_mode  = ctrl[`DPCT_CTRL_TIN_HI:`DPCT_CTRL_TIN_LO];

  // Address phase capture; write data lands in the following cycle
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end
    else if (hready)
    begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[11:0];
    end
  end

  always @(posedge ref_clk)
  begin
    t0_reload <= 1'b0;
    t1_reload <= 1'b0;
    if (rst)
    begin
      ctrl    <= {`DPCT_CTRL_WIDTH{1'b0}};
      t0_load <= 8'h00;
      t0_pre  <= 6'h00;
      t1_load <= 8'h00;
      t1_pre  <= 6'h00;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        `DPCT_ADDR_CTRL:
        begin
          ctrl      <= hwdata[`DPCT_CTRL_WIDTH-1:0];
          t0_reload <= hwdata[`DPCT_CMD_T0_RELOAD];
          t1_reload <= hwdata[`DPCT_CMD_T1_RELOAD];
        end
        `DPCT_ADDR_T0_LOAD: t0_load <= hwdata[7:0];
        `DPCT_ADDR_T0_PRE:  t0_pre  <= hwdata[5:0];
        `DPCT_ADDR_T1_LOAD: t1_load <= hwdata[7:0];
        `DPCT_ADDR_T1_PRE:  t1_pre  <= hwdata[5:0];
        default:
        begin
        end
      endcase
    end
  end

  // Reads are side-effect free; prescaler counters are not mapped
  always @(posedge ref_clk)
  begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (addr_ok && !hwrite)
    begin
      case (haddr[11:0])
        `DPCT_ADDR_CTRL:     hrdata <= {23'h000000, ctrl};
        `DPCT_ADDR_T0_LOAD:  hrdata <= {24'h000000, t0_load};
        `DPCT_ADDR_T0_PRE:   hrdata <= {26'h0000000, t0_pre};
        `DPCT_ADDR_T0_COUNT: hrdata <= {24'h000000, t0_count};
        `DPCT_ADDR_T1_LOAD:  hrdata <= {24'h000000, t1_load};
        `DPCT_ADDR_T1_PRE:   hrdata <= {26'h0000000, t1_pre};
        `DPCT_ADDR_T1_COUNT: hrdata <= {24'h000000, t1_count};
        `DPCT_ADDR_STATUS:   hrdata <= {29'h00000000, trig_armed, tin_level, port3_line6};
        default:             hrdata <= 32'h00000000;
      endcase
    end
  end

  // Internal clock divided by four for timer one
  always @(posedge ref_clk)
  begin
    if (rst)
      int_div <= 2'h0;
    else
      int_div <= int_div + 2'h1;
  end
  assign int_tick = (int_div == `DPCT_INT_DIV);

  // Pin input crosses into ref_clk before any edge logic
  dpct_sync u_tin_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (port3_line1),
    .level   (tin_level),
    .rise    (tin_rise)
  );

  // Trigger modes: a rising edge arms timer one; retrigger reloads it
  always @(posedge ref_clk)
  begin
    if (rst || t1_reload || !ctrl[`DPCT_CTRL_T1_RUN])
      trig_armed <= 1'b0;
    else if (t1_done && !ctrl[`DPCT_CTRL_T1_CONT])
      trig_armed <= 1'b0;
    else if (tin_rise)
      trig_armed <= 1'b1;
  end

  always @*
  begin
    t1_tick = int_tick;
    t1_run  = ctrl[`DPCT_CTRL_T1_RUN];
    if (ctrl[`DPCT_CTRL_CASCADE])
      t1_tick = t0_done;
    else if (ctrl[`DPCT_CTRL_T1_EXT])
    begin
      case (tin_mode)
        `DPCT_TIN_CLOCK:   t1_tick = tin_rise;
        `DPCT_TIN_GATE:    t1_run  = t1_run && tin_level;
        `DPCT_TIN_TRIG_NR: t1_run  = t1_run && trig_armed;
        `DPCT_TIN_TRIG_R:  t1_run  = t1_run && trig_armed;
        default:           t1_tick = int_tick;
      endcase
    end
  end

  // Retrigger restarts from the loaded value; non-retrigger ignores later edges
  wire t1_retrig = ctrl[`DPCT_CTRL_T1_EXT] && !ctrl[`DPCT_CTRL_CASCADE]
                   && (tin_mode == `DPCT_TIN_TRIG_R) && tin_rise && trig_armed;

  dpct_timer u_timer_zero (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (1'b1),
    .run      (ctrl[`DPCT_CTRL_T0_RUN]),
    .cont     (ctrl[`DPCT_CTRL_T0_CONT]),
    .reload   (t0_reload),
    .load_val (t0_load),
    .pre_val  (t0_pre),
    .count    (t0_count),
    .done     (t0_done)
  );

  dpct_timer u_timer_one (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (t1_tick),
    .run      (t1_run),
    .cont     (ctrl[`DPCT_CTRL_T1_CONT]),
    .reload   (t1_reload || t1_retrig),
    .load_val (t1_load),
    .pre_val  (t1_pre),
    .count    (t1_count),
    .done     (t1_done)
  );

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      timer_zero_irq <= 1'b0;
      timer_one_irq  <= 1'b0;
      port3_line6    <= 1'b0;
    end
    else
    begin
      timer_zero_irq <= t0_done;
      timer_one_irq  <= t1_done;
      if (t1_done && ctrl[`DPCT_CTRL_TOUT_EN])
        port3_line6 <= !port3_line6;
    end
  end

endmodule
`default_nettype wire

/* verif/dpct_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dpct_asserts (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        port3_line6,
  input wire logic        timer_zero_irq,
  input wire logic        timer_one_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic       rd;
  logic       wr_q;
  logic [8:0] ctl;
  assign rd = hready && htrans[1] && !hwrite;
  // Control shadow follows the write data phase, as the design does
  always @(posedge ref_clk)
  begin
    wr_q <= !rst && hready && htrans[1] && hwrite && haddr[11:0] == 12'h000;
    ctl  <= rst ? 9'h000 : (wr_q ? hwdata[8:0] : ctl);
  end
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready");
  chk_unmapped_zero: assert property (rd && haddr[11:0] > 12'h01C |=> hrdata == 32'h0)
    else $error("unmapped read");
  chk_count_width: assert property (rd && haddr[11:0] == 12'h00C |=> hrdata[31:8] == 24'h0)
    else $error("count width");
  chk_ctrl_readback: assert property (rd && haddr[11:0] == 12'h000 && !wr_q |=> hrdata[8:0] == ctl)
    else $error("control readback");
  // An end of count needs the run bit as it stood at the edge before the request
  chk_zero_run: assert property (timer_zero_irq |-> $past(ctl[0]))
    else $error("timer zero irq while stopped");
  chk_one_run: assert property (timer_one_irq |-> $past(ctl[2]))
    else $error("timer one irq while stopped");
  chk_out_cause: assert property ($changed(port3_line6) |-> timer_one_irq)
    else $error("output toggled without end");
  chk_out_toggle: assert property (timer_one_irq && $past(ctl[8]) |-> $changed(port3_line6))
    else $error("output did not toggle");
  chk_out_hold: assert property (timer_one_irq && !$past(ctl[8]) |-> $stable(port3_line6))
    else $error("output toggled while disabled");
endmodule
bind dpct_top dpct_asserts u_dpct_asserts (.*);
`default_nettype wire

/* verif/dpct_src.sv */
`timescale 1ns/1ps
`default_nettype none
module dpct_src (
  output var logic line
);
  initial line = 1'b0;
  // Edges sit off the clock grid, so the input is truly asynchronous
  task automatic pulse(input int hi_ns);
    #7 line = 1'b1;
    #(hi_ns) line = 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hsel = 1'b1;
  logic [31:0] rv;
  int          err_count = 0, n_checks = 0, n0 = 0, n1 = 0, a, b, k;
  wire  [31:0] hrdata;
  wire         hready, hreadyout, hresp, port3_line1, port3_line6, timer_zero_irq, timer_one_irq;
  assign hready = hreadyout;
  dpct_top u_dpct_top (.*);
  dpct_src u_dpct_src (.line(port3_line1));
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    n0 <= n0 + (timer_zero_irq === 1'b1);
    n1 <= n1 + (timer_one_irq === 1'b1);
  end
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    haddr <= {20'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic arm(input int t, input logic [7:0] l, input logic [5:0] p, input logic [31:0] c);
    bus(1'b1, 12'h000, 32'h0);
    bus(1'b1, t ? 12'h010 : 12'h004, {24'h0, l});
    bus(1'b1, t ? 12'h014 : 12'h008, {26'h0, p});
    bus(1'b1, 12'h000, c | (32'h1 << (16 + t)));
  endtask
  // Sampled mid-cycle so registered pulses have settled
  task automatic wq(input int t, output int n);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while ((t ? timer_one_irq : timer_zero_irq) !== 1'b1 && n < 5000);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b1, 12'h020, 32'hFFFFFFFF);
    bus(1'b0, 12'h020, 32'h0);
    chk(rv, 32'h0);
    arm(0, 8'h02, 6'h00, 32'h1);
    wq(0, a);
    arm(0, 8'h02, 6'h3F, 32'h1);
    wq(0, b);
    chk(b - a, 126);
    arm(0, 8'h01, 6'h00, 32'h1);
    wq(0, a);
    arm(0, 8'h00, 6'h00, 32'h1);
    wq(0, b);
    chk(b - a, 255);
    bus(1'b0, 12'h00C, 32'h0);
    chk(rv, 32'h0);
    // A first timer one end lines up the divide-by-four phase for both timed runs
    arm(1, 8'h01, 6'h00, 32'h4);
    wq(1, a);
    arm(1, 8'h01, 6'h00, 32'h4);
    wq(1, a);
    arm(1, 8'h02, 6'h00, 32'h4);
    wq(1, b);
    chk(b - a, 4);
    arm(0, 8'h03, 6'h00, 32'h3);
    wq(0, a);
    wq(0, b);
    chk(b, 3);
    bus(1'b1, 12'h000, 32'h2);
    bus(1'b0, 12'h00C, 32'h0);
    k = n0;
    a = rv;
    repeat (20) @(negedge ref_clk);
    bus(1'b0, 12'h00C, 32'h0);
    chk(rv, a);
    chk(n0 - k, 0);
    bus(1'b1, 12'h000, 32'h3);
    wq(0, b);
    // Resume goes on from the held count; a restart would take one tick longer
    chk(b, a + 2);
    arm(1, 8'h02, 6'h00, 32'h8F);
    wq(1, a);
    wq(1, b);
    chk(b, 6);
    for (int m = 0; m < 4; m++)
    begin
      arm(1, 8'h01, 6'h00, 32'h114 | (m << 5));
      k = n1;
      repeat (40) @(negedge ref_clk);
      chk(n1 - k, 0);
      u_dpct_src.pulse(3000);
      repeat (10) @(negedge ref_clk);
      chk(n1 - k, 1);
      chk(port3_line6, !m[0]);
    end
    bus(1'b0, 12'h000, 32'h0);
    chk(rv & 32'h1FF, 32'h174);
    complete_run;
  end
  initial
  begin
    #1000000;
    err_count++;
    complete_run;
  end
endmodule
`default_nettype wire
